// >>> dv/sef_comparator_model.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Phase comparator on the unexcited winding
module sef_comparator_model
(
  // Commands
  input  wire logic level,
  input  wire logic glitch,
  // Comparator level toward the block
  output var  logic comparator_out
);
  // A commanded glitch flips the level, as switching noise would
  assign comparator_out = level ^ glitch;
endmodule : sef_comparator_model
`default_nettype wire

// >>> dv/sef_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sef_top_bench
  import sef_pkg::*;
;
  localparam int UNIT = 16;
  localparam logic [7:0]  RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  localparam logic [31:0] RV [8] = '{32'h0, 32'h0f, 32'h0f, 32'h09, 32'h0, 32'h0, 32'h0, 32'h0};
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        hw_comm = 1'b0;
  logic        level   = 1'b0;
  logic        glitch  = 1'b0;
  int          n_fail  = 0;
  int          n_compared = 0;
  wire logic        awready, wready, bvalid, arready, rvalid, cmp, devt, zevt, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;

  sef_comparator_model u_cmp (.level(level), .glitch(glitch), .comparator_out(cmp));

  sef_top #(.ADDR_W(8), .WIN_UNIT_CYC(UNIT)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_out(cmp),
    .hw_commutation(hw_comm), .demag_event(devt), .zero_cross_event(zevt), .irq(irq)
  );

  initial
  begin
    forever #5 aclk = ~aclk;
  end

  // ====================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    check(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask : rd

  // Counts cycles up to the event; 3000 means it never came
  task automatic wait_evt(input logic zc, output int lat);
    lat = 0;
    do
    begin
      @(posedge aclk);
      lat++;
    end
    while ((zc ? zevt : devt) !== 1'b1 && lat < 3000);
  endtask : wait_evt

  task automatic comm();
    @(posedge aclk);
    hw_comm <= 1'b1;
    @(posedge aclk);
    hw_comm <= 1'b0;
  endtask : comm

  task automatic run(output int ld, output int lz);
    comm();
    wait_evt(1'b0, ld);
    wait_evt(1'b1, lz);
  endtask : run

  function automatic int units(input int c);
    return (c < 8) ? c + 1 : 12 + 4 * (c - 8);
  endfunction : units

  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // ====================================================================
  // Main sequence
  initial
  begin
    logic [31:0] v;
    int          ld, lz, d0, z0, l15, lg;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(RA[i], (i == 7) ? RESP_SLVERR : RESP_OKAY, v);
      check(v, RV[i]);
    end
    wr(8'h1c, 32'h1, 4'hf, RESP_SLVERR);
    wr(8'h0c, 32'h0, 4'h1, RESP_OKAY);
    // Window sweep: latencies relative to code zero isolate the window length
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h04, 32'(c), 4'h1, RESP_OKAY);
      wr(8'h08, 32'(c), 4'h1, RESP_OKAY);
      run(ld, lz);
      if (c == 0)
      begin
        d0 = ld;
        z0 = lz;
        check(32'(d0 >= UNIT && z0 >= UNIT), 32'h1);
      end
      check(32'(ld - d0), 32'((units(c) - 1) * UNIT));
      check(32'(lz - z0), 32'((units(c) - 1) * UNIT));
    end
    rd(8'h18, RESP_OKAY, v);
    check(v, 32'h1010);
    wr(8'h18, 32'h0, 4'h1, RESP_OKAY);
    wr(8'h04, 32'hf0, 4'h1, RESP_OKAY);
    wr(8'h08, 32'h00, 4'h1, RESP_OKAY);
    run(l15, lz);
    check(32'(l15 - d0), 32'd15);
    comm();
    repeat (UNIT + 8) @(posedge aclk);
    glitch <= 1'b1;
    @(posedge aclk);
    glitch <= 1'b0;
    wait_evt(1'b0, lg);
    check(32'(lg + UNIT + 9 >= l15 + 5), 32'h1);
    wait_evt(1'b1, lz);
    wr(8'h0c, 32'h3, 4'h1, RESP_OKAY);
    run(lg, lz);
    check(32'(lg >= l15 + 45), 32'h1);
    wr(8'h0c, 32'h0, 4'h1, RESP_OKAY);
    wr(8'h00, 32'h100, 4'h2, RESP_OKAY);
    wait_evt(1'b0, lg);
    check(32'(lg > 15 && lg < 3000), 32'h1);
    wait_evt(1'b1, lz);
    wr(8'h04, 32'h0f, 4'h1, RESP_OKAY);
    wr(8'h00, 32'h1, 4'h1, RESP_OKAY);
    run(lg, lz);
    check(32'(lg < d0), 32'h1);
    wr(8'h04, 32'hff, 4'h1, RESP_OKAY);
    wr(8'h08, 32'hff, 4'h1, RESP_OKAY);
    wr(8'h00, 32'h0, 4'h1, RESP_OKAY);
    comm();
    fork
      wr(8'h00, 32'h200, 4'h2, RESP_OKAY);
      wait_evt(1'b0, lg);
    join
    check(32'(lg < 12), 32'h1);
    fork
      wr(8'h00, 32'h400, 4'h2, RESP_OKAY);
      wait_evt(1'b1, lg);
    join
    check(32'(lg < 12), 32'h1);
    wr(8'h00, 32'h2, 4'h1, RESP_OKAY);
    // Comparator off the expected level, so no hardware event hides the refusal
    level <= 1'b1;
    fork
      wr(8'h00, 32'h402, 4'h3, RESP_OKAY);
      wait_evt(1'b1, lg);
    join
    check(32'(lg), 32'd3000);
    // Interrupt: flags are already set by the events above
    rd(8'h10, RESP_OKAY, v);
    check(v & 32'h3, 32'h3);
    check(32'(irq), 32'h0);
    wr(8'h14, 32'h3, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h1);
    wr(8'h10, 32'h3, 4'h1, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'(irq), 32'h0);
    rd(8'h10, RESP_OKAY, v);
    check(v & 32'h3, 32'h0);
    wrap_up();
  end

  initial
  begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    wrap_up();
  end
endmodule : sef_top_bench
`default_nettype wire

// >>> dv/sef_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Port-level checks on the event filters and the register bus
module sef_top_sva
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Events and interrupt
  input wire logic        demag_event,
  input wire logic        zero_cross_event,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_D_PULSE: assert property (demag_event |=> !demag_event)
    else $error("demag event longer than one cycle");
  AST_Z_PULSE: assert property (zero_cross_event |=> !zero_cross_event)
    else $error("zero-cross event longer than one cycle");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_AW_BUSY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_awready && !s_axi_wready)
    else $error("write slots not closed after take");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
  // A rise needs an event one cycle back or a mask write just done
  AST_IRQ_RISE: assert property ($rose(irq) |-> $past(demag_event)
    || $past(zero_cross_event) || $past(s_axi_bvalid))
    else $error("interrupt rose without cause");
  // A status clear drops irq with the response; a mask clear one cycle later
  AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt fell without a write");
endmodule : sef_top_sva

bind sef_top sef_top_sva u_sva (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .demag_event(demag_event), .zero_cross_event(zero_cross_event), .irq(irq)
);
`default_nettype wire

// >>> src/sef_event_filter.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Blanking window followed by a consecutive-sample counter
module sef_event_filter
  import sef_pkg::*;
#(
  parameter int UNIT_CYC = WIN_UNIT_CYCLES
)
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Sequencing
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       strict,
  input  wire logic       no_window,
  // Samples
  input  wire logic       sample_tick,
  input  wire logic       detect,
  input  wire logic       sim,
  // Settings
  input  wire logic [3:0] window_code,
  input  wire logic [3:0] count_limit,
  // Result
  output var  logic       event_pulse,
  output var  logic       armed
);

  localparam int CW = $clog2(UNIT_CYC + 1);

  sef_flt_state_t state;
  sef_flt_state_t next_state;
  logic [CW-1:0]  cyc_cnt;
  logic [5:0]     unit_cnt;
  logic [4:0]     run;

  wire [5:0] win_units = sef_win_units(window_code);
  wire       blanking  = state == FLT_BLANK;
  wire       counting  = state == FLT_COUNT;
  wire       unit_end  = cyc_cnt == CW'(UNIT_CYC - 1);
  wire       win_end   = unit_end & (unit_cnt == win_units - 6'h01);
  wire       hit       = counting & sample_tick & detect;
  wire       hw_fire   = hit & (run == {1'b0, count_limit});
  // Simulated events skip the counter; in strict order only while armed
  wire       sim_fire  = sim & (~strict | (state != FLT_IDLE));
  wire       fire      = hw_fire | sim_fire;

  // ====================================================================
  // Sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      FLT_IDLE:  next_state = FLT_IDLE;
      FLT_BLANK: if (no_window | win_end) next_state = FLT_COUNT;
      FLT_COUNT: next_state = FLT_COUNT;
      default:   next_state = FLT_IDLE;
    endcase
    if (fire)
      next_state = FLT_IDLE;
    if (abort)
      next_state = FLT_IDLE;
    if (start)
      next_state = no_window ? FLT_COUNT : FLT_BLANK;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state       <= FLT_IDLE;
      cyc_cnt     <= '0;
      unit_cnt    <= 6'h00;
      run         <= 5'h00;
      event_pulse <= 1'b0;
      armed       <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      event_pulse <= fire;
      armed       <= next_state != FLT_IDLE;
      cyc_cnt     <= (start | ~blanking | unit_end) ? '0 : cyc_cnt + CW'(1);
      unit_cnt    <= (start | ~blanking) ? 6'h00 : unit_cnt + {5'h00, unit_end};
      if (start | ~counting | fire)
        run <= 5'h00;
      else if (sample_tick)
        run <= detect ? run + 5'h01 : 5'h00;
    end
  end

endmodule : sef_event_filter
`default_nettype wire

// >>> src/sef_pkg.sv
// ======================================================================
// Shared constants for the sensorless event filters
package sef_pkg;

  // ====================================================================
  // Timing
  localparam int CLK_FREQ_MHZ    = 100;
  localparam int WIN_UNIT_US     = 5;
  localparam int WIN_UNIT_CYCLES = WIN_UNIT_US * CLK_FREQ_MHZ;

  // Long window codes start at 60 us (12 units) and step by 20 us (4 units)
  localparam logic [5:0] WIN_LONG_BASE_UNITS = 6'h0c;

  // ====================================================================
  // Register byte offsets
  localparam int ADDR_CONTROL   = 'h00;
  localparam int ADDR_DEMAG_CFG = 'h04;
  localparam int ADDR_ZC_CFG    = 'h08;
  localparam int ADDR_SAMPLE    = 'h0c;
  localparam int ADDR_STATUS    = 'h10;
  localparam int ADDR_IRQ_MASK  = 'h14;
  localparam int ADDR_EVT_COUNT = 'h18;

  // ====================================================================
  // Field positions
  localparam int CTL_SENSOR_BIT    = 0;
  localparam int CTL_STRICT_BIT    = 1;
  localparam int CTL_DEMAG_LVL_BIT = 2;
  localparam int CTL_ZC_LVL_BIT    = 3;
  localparam int CTL_SW_COMM_BIT   = 8;
  localparam int CTL_SIM_DEMAG_BIT = 9;
  localparam int CTL_SIM_ZC_BIT    = 10;
  localparam int CFG_WIN_LSB       = 0;
  localparam int CFG_CNT_LSB       = 4;
  localparam int STAT_DEMAG_BIT    = 0;
  localparam int STAT_ZC_BIT       = 1;
  localparam int STAT_COMP_BIT     = 4;
  localparam int STAT_D_ARMED_BIT  = 5;
  localparam int STAT_Z_ARMED_BIT  = 6;

  // ====================================================================
  // Reset values
  localparam logic [3:0] CONTROL_RST    = 4'h0;
  localparam logic [3:0] WIN_CODE_RST   = 4'hf;
  localparam logic [3:0] CNT_LIMIT_RST  = 4'h0;
  localparam logic [7:0] SAMPLE_DIV_RST = 8'h09;
  localparam logic [1:0] IRQ_MASK_RST   = 2'h0;

  // ====================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {FLT_IDLE, FLT_BLANK, FLT_COUNT} sef_flt_state_t;

  // Window length in 5 us units
  function automatic logic [5:0] sef_win_units(input logic [3:0] code);
    if (!code[3])
    begin
      return {2'h0, code} + 6'h01;
    end
    return WIN_LONG_BASE_UNITS + {1'b0, code[2:0], 2'h0};
  endfunction : sef_win_units

endpackage : sef_pkg

// >>> src/sef_sample_tick.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Sampling strobe: one pulse every divider+1 clock cycles
module sef_sample_tick
  import sef_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic [7:0] divider,
  // Strobe
  output var  logic       tick
);

  logic [7:0] cnt;
  wire        wrap = cnt >= divider;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= wrap ? 8'h00 : cnt + 8'h01;
      tick <= wrap;
    end
  end

endmodule : sef_sample_tick
`default_nettype wire

// >>> src/sef_top.sv
`timescale 1ns/100ps
`default_nettype none
module sef_top
  import sef_pkg::*;
#(
  parameter int ADDR_W       = 8,
  parameter int WIN_UNIT_CYC = WIN_UNIT_CYCLES
)
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Motor side
  input  wire logic              comparator_out,
  input  wire logic              hw_commutation,
  // Events and interrupt
  output var  logic              demag_event,
  output var  logic              zero_cross_event,
  output var  logic              irq
);

  // ====================================================================
  // Declarations
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [3:0]        control;
  logic [7:0]        demag_filter_config;
  logic [7:0]        zero_cross_filter_config;
  logic [7:0]        sample_div;
  logic [1:0]        status;
  logic [1:0]        irq_mask;
  logic [7:0]        demag_total;
  logic [7:0]        zero_cross_total;
  logic              sw_commutation;
  logic              sim_demag;
  logic              sim_zero_cross;
  logic              comp_meta;
  logic              comp_sync;
  logic              sample_tick;
  logic              demag_armed;
  logic              zero_cross_armed;

  // ====================================================================
  // Bus handshakes
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire b_done   = s_axi_bvalid & s_axi_bready;
  wire r_done   = s_axi_rvalid & s_axi_rready;
  // Both halves held and no response outstanding
  wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  // ====================================================================
  // Address decode
  wire [ADDR_W-1:0] wr_word = {aw_addr[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  wire wr_control = wr_word == ADDR_W'(ADDR_CONTROL);
  wire wr_demag   = wr_word == ADDR_W'(ADDR_DEMAG_CFG);
  wire wr_zc      = wr_word == ADDR_W'(ADDR_ZC_CFG);
  wire wr_sample  = wr_word == ADDR_W'(ADDR_SAMPLE);
  wire wr_status  = wr_word == ADDR_W'(ADDR_STATUS);
  wire wr_mask    = wr_word == ADDR_W'(ADDR_IRQ_MASK);
  wire wr_counts  = wr_word == ADDR_W'(ADDR_EVT_COUNT);
  wire wr_hit     = wr_control | wr_demag | wr_zc | wr_sample | wr_status
                  | wr_mask | wr_counts;

  wire rd_control = rd_word == ADDR_W'(ADDR_CONTROL);
  wire rd_demag   = rd_word == ADDR_W'(ADDR_DEMAG_CFG);
  wire rd_zc      = rd_word == ADDR_W'(ADDR_ZC_CFG);
  wire rd_sample  = rd_word == ADDR_W'(ADDR_SAMPLE);
  wire rd_status  = rd_word == ADDR_W'(ADDR_STATUS);
  wire rd_mask    = rd_word == ADDR_W'(ADDR_IRQ_MASK);
  wire rd_counts  = rd_word == ADDR_W'(ADDR_EVT_COUNT);
  wire rd_hit     = rd_control | rd_demag | rd_zc | rd_sample | rd_status
                  | rd_mask | rd_counts;

  wire wr_byte0   = do_write & w_strb[0];
  wire wr_byte1   = do_write & w_strb[1];

  // ====================================================================
  // Read data selection
  wire [31:0] status_word = {25'h0, zero_cross_armed, demag_armed, comp_sync,
                             2'h0, status};
  wire [31:0] rd_data =
      rd_control ? {28'h0, control} :
      rd_demag   ? {24'h0, demag_filter_config} :
      rd_zc      ? {24'h0, zero_cross_filter_config} :
      rd_sample  ? {24'h0, sample_div} :
      rd_status  ? status_word :
      rd_mask    ? {30'h0, irq_mask} :
      rd_counts  ? {16'h0, zero_cross_total, demag_total} :
                   32'h0000_0000;

  // ====================================================================
  // Write channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      else if (b_done)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ====================================================================
  // Read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (r_done)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ====================================================================
  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control                  <= CONTROL_RST;
      demag_filter_config      <= {CNT_LIMIT_RST, WIN_CODE_RST};
      zero_cross_filter_config <= {CNT_LIMIT_RST, WIN_CODE_RST};
      sample_div               <= SAMPLE_DIV_RST;
      irq_mask                 <= IRQ_MASK_RST;
    end
    else
    begin
      if (wr_byte0 & wr_control)
        control <= w_data[3:0];
      if (wr_byte0 & wr_demag)
        demag_filter_config <= w_data[7:0];
      if (wr_byte0 & wr_zc)
        zero_cross_filter_config <= w_data[7:0];
      if (wr_byte0 & wr_sample)
        sample_div <= w_data[7:0];
      if (wr_byte0 & wr_mask)
        irq_mask <= w_data[1:0];
    end
  end

  // ====================================================================
  // Software strobes, one cycle each; they read back as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_commutation <= 1'b0;
      sim_demag      <= 1'b0;
      sim_zero_cross <= 1'b0;
    end
    else
    begin
      sw_commutation <= wr_byte1 & wr_control & w_data[CTL_SW_COMM_BIT];
      sim_demag      <= wr_byte1 & wr_control & w_data[CTL_SIM_DEMAG_BIT];
      sim_zero_cross <= wr_byte1 & wr_control & w_data[CTL_SIM_ZC_BIT];
    end
  end

  // ====================================================================
  // Comparator synchroniser; the pin is asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comparator_out;
      comp_sync <= comp_meta;
    end
  end

  // ====================================================================
  // Event qualification
  wire sensor_mode_select = control[CTL_SENSOR_BIT];
  wire strict_order       = control[CTL_STRICT_BIT];
  wire commutation        = hw_commutation | sw_commutation;
  wire demag_detect       = comp_sync == control[CTL_DEMAG_LVL_BIT];
  wire zero_cross_detect  = comp_sync == control[CTL_ZC_LVL_BIT];

  sef_sample_tick u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .divider (sample_div),
    .tick    (sample_tick)
  );

  sef_event_filter #(
    .UNIT_CYC (WIN_UNIT_CYC)
  ) u_demag (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (commutation),
    .abort       (1'b0),
    .strict      (strict_order),
    .no_window   (sensor_mode_select),
    .sample_tick (sample_tick),
    .detect      (demag_detect),
    .sim         (sim_demag),
    .window_code (demag_filter_config[CFG_WIN_LSB +: 4]),
    .count_limit (demag_filter_config[CFG_CNT_LSB +: 4]),
    .event_pulse (demag_event),
    .armed       (demag_armed)
  );

  // A new commutation in strict order abandons a pending zero-cross search
  sef_event_filter #(
    .UNIT_CYC (WIN_UNIT_CYC)
  ) u_zero_cross (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (demag_event),
    .abort       (commutation & strict_order),
    .strict      (strict_order),
    .no_window   (sensor_mode_select),
    .sample_tick (sample_tick),
    .detect      (zero_cross_detect),
    .sim         (sim_zero_cross),
    .window_code (zero_cross_filter_config[CFG_WIN_LSB +: 4]),
    .count_limit (zero_cross_filter_config[CFG_CNT_LSB +: 4]),
    .event_pulse (zero_cross_event),
    .armed       (zero_cross_armed)
  );

  // ====================================================================
  // Sticky flags, mask and interrupt; a new event beats a clear
  wire [1:0] flag_set   = {zero_cross_event, demag_event};
  wire [1:0] flag_clr   = (wr_byte0 & wr_status) ? w_data[1:0] : 2'h0;
  wire [1:0] next_status = (status & ~flag_clr) | flag_set;
  // Counter write of any value clears both totals
  wire       clr_totals = wr_byte0 & wr_counts;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status           <= 2'h0;
      irq              <= 1'b0;
      demag_total      <= 8'h00;
      zero_cross_total <= 8'h00;
    end
    else
    begin
      status           <= next_status;
      irq              <= |(next_status & irq_mask);
      demag_total      <= clr_totals ? 8'h00 : demag_total + {7'h00, demag_event};
      zero_cross_total <= clr_totals ? 8'h00
                                     : zero_cross_total + {7'h00, zero_cross_event};
    end
  end

endmodule : sef_top
`default_nettype wire
